// *** design/txsc_top.sv ***
`timescale 1ns/1ns
`include "txsc_map.svh"
module txsc_top
  import txsc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic tx_start_cmd,
  input wire logic poll_demand,
  input wire logic jabber_expired,
  input wire logic desc_unavailable,
  input wire logic desc_owned,
  input wire logic frame_done,
  input wire logic first_desc_irq_on_done,
  input wire logic link_fast,
  input wire logic [10:0] fifo_bytes,
  input wire logic frame_whole,
  output logic line_start_ok,
  output logic desc_jabber_flag,
  output logic sqe_test_en,
  output logic [2:0] tx_state,
  output logic irq
);
  //////////////////////////////////////////////////////////////////////////////
  txsc_state_e state;
  txsc_state_e next_state;
  logic [3:0] status;
  logic [3:0] mask;
  logic store_fwd;
  logic sqe_dis;
  logic [1:0] thr;
  logic ph_valid;
  logic ph_write;
  logic [11:0] ph_addr;
  txsc_ctl_if ctl ();
  txsc_level_t start_level;

  // Address phase capture for the data phase.
  wire addr_take = hsel & hready & htrans[1];
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ph_valid <= 1'b0;
      ph_write <= 1'b0;
      ph_addr <= 12'h000;
    end
    else
    begin
      ph_valid <= addr_take;
      ph_write <= hwrite;
      ph_addr <= haddr;
    end
  end

  // Write decode in the data phase; reads are decoded in the address phase.
  wire wr_status = ph_valid & ph_write & (ph_addr == `TXSC_OFF_STATUS);
  wire wr_access = ph_valid & ph_write & (ph_addr == `TXSC_OFF_ACCESS);
  wire wr_mask = ph_valid & ph_write & (ph_addr == `TXSC_OFF_MASK);
  wire rd_take = addr_take & ~hwrite;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  //////////////////////////////////////////////////////////////////////////////
  // Transmit state machine.
  wire stopped = (state == TXSC_STOP);
  always_comb
  begin
    next_state = state;
    case (state)
      TXSC_STOP:
      begin
        if (tx_start_cmd)
          next_state = TXSC_RUN;
      end
      TXSC_RUN:
      begin
        if (jabber_expired)
          next_state = TXSC_STOP;
        else if (desc_unavailable)
          next_state = TXSC_SUSP;
      end
      TXSC_SUSP:
      begin
        if (jabber_expired)
          next_state = TXSC_STOP;
        else if (desc_owned & poll_demand)
          next_state = TXSC_RUN;
      end
      default: next_state = TXSC_STOP;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      state <= TXSC_STOP;
    else
      state <= next_state;
  end
  assign tx_state = state;

  // Descriptor jabber flag pulses the cycle after an expiry outside the stopped state so the engine writes it back.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      desc_jabber_flag <= 1'b0;
    else
      desc_jabber_flag <= jabber_expired & ~stopped;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Status events; a set in the same cycle as a clear wins.
  wire [3:0] ev;
  assign ev[`TXSC_BIT_DONE] = frame_done & first_desc_irq_on_done;
  assign ev[`TXSC_BIT_STOPPED] = stopped;
  assign ev[`TXSC_BIT_UNAVAIL] = (state == TXSC_RUN) & desc_unavailable & ~jabber_expired;
  assign ev[`TXSC_BIT_JABBER] = jabber_expired & ~stopped;
  wire [3:0] clr = wr_status ? hwdata[3:0] : 4'h0;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_stat
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
          status[gi] <= 1'b0;
        else
          status[gi] <= ev[gi] | (status[gi] & ~clr[gi]);
      end
    end
  endgenerate

  wire normal_sum = status[`TXSC_BIT_DONE] | status[`TXSC_BIT_UNAVAIL];
  wire abnormal_sum = status[`TXSC_BIT_STOPPED] | status[`TXSC_BIT_JABBER];

  //////////////////////////////////////////////////////////////////////////////
  // Access control and mask registers; access fields apply only while stopped, the mask at any time.
  wire acc_ok = wr_access & stopped;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      store_fwd <= `TXSC_RST_STORE_FWD;
      sqe_dis <= `TXSC_RST_SQE_DIS;
      thr <= `TXSC_RST_THR;
      mask <= 4'h0;
    end
    else
    begin
      if (acc_ok)
      begin
        store_fwd <= hwdata[`TXSC_BIT_STORE_FWD];
        sqe_dis <= hwdata[`TXSC_BIT_SQE_DIS];
        thr <= hwdata[`TXSC_BIT_THR_HI:`TXSC_BIT_THR_LO];
      end
      if (wr_mask)
        mask <= hwdata[3:0];
    end
  end

  // SQE test only runs on the slow line rate.
  assign sqe_test_en = ~sqe_dis & ~link_fast;

  // Interrupt output follows unmasked status.
  assign irq = |(status & mask);

  //////////////////////////////////////////////////////////////////////////////
  // Read data multiplexer.
  wire [31:0] rd_status = {15'h0000, normal_sum, abnormal_sum, 11'h000, status};
  wire [31:0] rd_access = {10'h000, store_fwd, 1'b0, sqe_dis, 3'h0, thr, 14'h0000};
  wire [31:0] rd_mask = {28'h0000000, mask};
  wire [31:0] rd_sel = (haddr == `TXSC_OFF_STATUS) ? rd_status :
                       (haddr == `TXSC_OFF_ACCESS) ? rd_access :
                       (haddr == `TXSC_OFF_MASK) ? rd_mask : 32'h00000000;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h00000000;
    else if (rd_take)
      hrdata <= rd_sel;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Start decision.
  assign ctl.store_fwd = store_fwd;
  assign ctl.tx_threshold_sel = thr;
  assign ctl.fast = link_fast;
  txsc_start u_start (
    .ctl(ctl),
    .fifo_bytes(fifo_bytes),
    .frame_whole(frame_whole),
    .start_ok(line_start_ok),
    .level(start_level)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Checks.
  a_jabber_stops: assert property (@(posedge hclk) disable iff (!hresetn)
    (jabber_expired && state != TXSC_STOP) |=> (state == TXSC_STOP) && status[3])
    else $error("Jabber expiry did not stop and flag.");
  a_unavail_susp: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == TXSC_RUN && desc_unavailable && !jabber_expired) |=> state == TXSC_SUSP && status[2])
    else $error("Unavailable descriptor did not suspend.");
  a_stop_status: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == TXSC_STOP) |=> status[1])
    else $error("Stopped state not reported.");
  a_done_gated: assert property (@(posedge hclk) disable iff (!hresetn)
    ($rose(status[0])) |-> $past(frame_done) && $past(first_desc_irq_on_done))
    else $error("Done status set without cause.");
  a_status_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_status && hwdata[3] && !ev[3]) |=> !status[3])
    else $error("Write one did not clear.");
  a_status_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
    (status[0] && !(wr_status && hwdata[0])) |=> status[0])
    else $error("Status bit dropped.");
  a_fwd_ignore: assert property (@(posedge hclk) disable iff (!hresetn)
    (store_fwd && !frame_whole) |-> !line_start_ok)
    else $error("Store-and-forward started early.");
  a_sqe_follow: assert property (@(posedge hclk) disable iff (!hresetn)
    (acc_ok && !hwdata[19]) |=> (sqe_test_en == !link_fast))
    else $error("SQE enable wrong.");
  a_thr_start: assert property (@(posedge hclk) disable iff (!hresetn)
    (!store_fwd && link_fast && thr == 2'h0 && fifo_bytes >= 11'h080) |-> line_start_ok)
    else $error("Threshold start missed.");

  // State machine checks beyond the basic transitions.
  a_jabber_flag: assert property (@(posedge hclk) disable iff (!hresetn)
    (jabber_expired && state != TXSC_STOP) |=> desc_jabber_flag)
    else $error("Descriptor jabber flag not raised.");
  a_flag_single: assert property (@(posedge hclk) disable iff (!hresetn)
    desc_jabber_flag |=> !desc_jabber_flag)
    else $error("Descriptor jabber flag held too long.");
  a_resume_run: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == TXSC_SUSP && desc_owned && poll_demand && !jabber_expired) |=> state == TXSC_RUN)
    else $error("Suspended transmit did not resume.");
  a_susp_holds: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == TXSC_SUSP && !(desc_owned && poll_demand) && !jabber_expired) |=> state == TXSC_SUSP)
    else $error("Suspended transmit left without cause.");
  a_stop_holds: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == TXSC_STOP && !tx_start_cmd) |=> state == TXSC_STOP)
    else $error("Stopped transmit left without a start.");
  a_state_onehot: assert property (@(posedge hclk) disable iff (!hresetn)
    $onehot(state))
    else $error("Transmit state not one-hot.");

  // Status latch, clear and summary checks.
  a_done_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_status && hwdata[0] && !ev[0]) |=> !status[0])
    else $error("Write one did not clear done.");
  a_rd_status: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_take && haddr == `TXSC_OFF_STATUS) |=> hrdata[3:0] == $past(status))
    else $error("Status read data wrong.");
  a_normal_sum: assert property (@(posedge hclk) disable iff (!hresetn)
    (ev[0] || ev[2]) |=> rd_status[16])
    else $error("Normal summary missing.");
  a_abnormal_sum: assert property (@(posedge hclk) disable iff (!hresetn)
    (ev[1] || ev[3]) |=> rd_status[15])
    else $error("Abnormal summary missing.");

  // Control field checks; a running engine keeps its fields.
  a_access_locked: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_access && !stopped) |=> $stable(store_fwd) && $stable(sqe_dis) && $stable(thr))
    else $error("Control fields changed while running.");
  a_access_taken: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_access && stopped) |=> store_fwd == $past(hwdata[`TXSC_BIT_STORE_FWD]) &&
      thr == $past(hwdata[`TXSC_BIT_THR_HI:`TXSC_BIT_THR_LO]))
    else $error("Control write not taken while stopped.");
  a_sqe_fast_off: assert property (@(posedge hclk) disable iff (!hresetn)
    link_fast |-> !sqe_test_en)
    else $error("SQE test enabled on the fast line rate.");

  // Start level checks at the slow rate and below the level.
  a_slow_start: assert property (@(posedge hclk) disable iff (!hresetn)
    (!store_fwd && !link_fast && thr == 2'h3 && fifo_bytes >= `TXSC_LVL_S3) |-> line_start_ok)
    else $error("Slow threshold start missed.");
  a_thr_wait: assert property (@(posedge hclk) disable iff (!hresetn)
    (!frame_whole && fifo_bytes < start_level) |-> !line_start_ok)
    else $error("Frame started below the level.");

  // Coverage of the main scenarios.
  c_jabber: cover property (@(posedge hclk) disable iff (!hresetn) state == TXSC_RUN ##1 state == TXSC_STOP);
  c_unavail: cover property (@(posedge hclk) disable iff (!hresetn) state == TXSC_RUN ##1 state == TXSC_SUSP);
  c_resume: cover property (@(posedge hclk) disable iff (!hresetn) state == TXSC_SUSP ##1 state == TXSC_RUN);
  c_irq: cover property (@(posedge hclk) disable iff (!hresetn) $rose(irq));
  c_clear: cover property (@(posedge hclk) disable iff (!hresetn) $fell(status[0]));
endmodule

// *** design/txsc_map.svh ***
`ifndef TXSC_MAP_SVH
`define TXSC_MAP_SVH
// Register byte offsets.
`define TXSC_OFF_STATUS 12'h000
`define TXSC_OFF_ACCESS 12'h004
`define TXSC_OFF_MASK 12'h008
// Status bit positions.
`define TXSC_BIT_DONE 0
`define TXSC_BIT_STOPPED 1
`define TXSC_BIT_UNAVAIL 2
`define TXSC_BIT_JABBER 3
`define TXSC_BIT_ABNORMAL 15
`define TXSC_BIT_NORMAL 16
// Access register field positions.
`define TXSC_BIT_STORE_FWD 21
`define TXSC_BIT_SQE_DIS 19
`define TXSC_BIT_THR_HI 15
`define TXSC_BIT_THR_LO 14
// Descriptor flag positions.
`define TXSC_BIT_DESC_JABBER 14
`define TXSC_BIT_DESC_IRQ 31
// Reset values.
`define TXSC_RST_STATUS 4'h0
`define TXSC_RST_STORE_FWD 1'h0
`define TXSC_RST_SQE_DIS 1'h1
`define TXSC_RST_THR 2'h0
// Start levels in bytes, fast then slow line rate.
`define TXSC_LVL_F0 11'h080
`define TXSC_LVL_F1 11'h100
`define TXSC_LVL_F2 11'h200
`define TXSC_LVL_F3 11'h400
`define TXSC_LVL_S0 11'h048
`define TXSC_LVL_S1 11'h060
`define TXSC_LVL_S2 11'h080
`define TXSC_LVL_S3 11'h0a0
`endif

// *** design/txsc_pkg.sv ***
package txsc_pkg;
  typedef enum logic [2:0] {
    TXSC_STOP = 3'b001,
    TXSC_RUN = 3'b010,
    TXSC_SUSP = 3'b100
  } txsc_state_e;
  typedef logic [10:0] txsc_level_t;
endpackage

// *** design/txsc_ctl_if.sv ***
`timescale 1ns/1ns
// Carries the transmit control fields from the register file to the start logic.
interface txsc_ctl_if;
  logic store_fwd;
  logic [1:0] tx_threshold_sel;
  logic fast;
  modport src (output store_fwd, output tx_threshold_sel, output fast);
  modport dst (input store_fwd, input tx_threshold_sel, input fast);
endinterface

// *** design/txsc_start.sv ***
`timescale 1ns/1ns
`include "txsc_map.svh"
// Decides when a frame may start on the line.
module txsc_start
  import txsc_pkg::*;
(
  txsc_ctl_if.dst ctl,
  input wire logic [10:0] fifo_bytes,
  input wire logic frame_whole,
  output logic start_ok,
  output txsc_level_t level
);
  // Start level lookup by line rate and code.
  always_comb
  begin
    case ({ctl.fast, ctl.tx_threshold_sel})
      3'h4: level = `TXSC_LVL_F0;
      3'h5: level = `TXSC_LVL_F1;
      3'h6: level = `TXSC_LVL_F2;
      3'h7: level = `TXSC_LVL_F3;
      3'h0: level = `TXSC_LVL_S0;
      3'h1: level = `TXSC_LVL_S1;
      3'h2: level = `TXSC_LVL_S2;
      default: level = `TXSC_LVL_S3;
    endcase
  end
  // Store-and-forward waits for the whole frame; otherwise the level or the whole frame.
  assign start_ok = frame_whole | (~ctl.store_fwd & (fifo_bytes >= level));
endmodule

// *** verif/txsc_eng_model.sv ***
`timescale 1ns/1ns
// Stands in for the descriptor engine and host poll path.
// Bits: 0 start, 1 poll, 2 jabber, 3 unavail, 4 owned, 5 done, 6 irq flag.
module txsc_eng_model
(
  input wire logic hclk,
  output logic [6:0] ev
);
  initial ev = 7'h00;
  // Holds one event pattern for exactly one clock.
  task automatic pulse(input logic [6:0] m);
    @(posedge hclk);
    ev <= m;
    @(posedge hclk);
    ev <= 7'h00;
  endtask
  // Gives the descriptor back and demands a poll together.
  task automatic resume();
    pulse(7'h12);
  endtask
endmodule

// *** verif/tb.sv ***
`timescale 1ns/1ns
// Self-checking bench for the transmit status and control block.
module tb;
  logic hclk = 1'b0;
  logic hresetn;
  logic hsel, hwrite, frame_whole, link_fast;
  logic hready, hresp, line_start_ok, desc_jabber_flag, sqe_test_en, irq;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [2:0] tx_state;
  logic [31:0] hwdata, hrdata, rd;
  logic [10:0] fifo_bytes;
  logic [6:0] ev;
  int error_cnt = 0;
  int compares = 0;
  localparam logic [10:0] LVL [8] = '{11'h080, 11'h100, 11'h200, 11'h400, 11'h048, 11'h060, 11'h080, 11'h0a0};
  always #5 hclk = ~hclk;
  //////////////////////////////////////////////////////////////////////
  // Block under test and the engine beside it.
  txsc_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .tx_start_cmd(ev[0]), .poll_demand(ev[1]),
    .jabber_expired(ev[2]), .desc_unavailable(ev[3]), .desc_owned(ev[4]), .frame_done(ev[5]),
    .first_desc_irq_on_done(ev[6]), .link_fast(link_fast), .fifo_bytes(fifo_bytes),
    .frame_whole(frame_whole), .line_start_ok(line_start_ok), .desc_jabber_flag(desc_jabber_flag),
    .sqe_test_en(sqe_test_en), .tx_state(tx_state), .irq(irq));
  txsc_eng_model eng_u (.hclk(hclk), .ev(ev));
  //////////////////////////////////////////////////////////////////////
  // Compares one value and counts it.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      error_cnt++;
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // One single AHB transfer; waits on hready under a bound.
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do
    begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do
    begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    rd = hrdata;
    if (n >= 50)
    begin
      error_cnt++;
      tally_and_finish();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  //////////////////////////////////////////////////////////////////////
  // Reset values and an unmapped write.
  task automatic t_reset();
    rdc(12'h000, 32'h0000_8002);
    rdc(12'h004, 32'h0008_0000);
    wr(12'h00c, 32'h0000_000f);
    chk(hresp, 32'h0);
    rdc(12'h000, 32'h0000_8002);
    chk(sqe_test_en, 32'h0);
    $display("reset test done");
  endtask
  // Latching, clearing and the completion flag.
  task automatic t_done();
    eng_u.pulse(7'h01);
    #1;
    chk(tx_state, 32'h2);
    rdc(12'h000, 32'h0000_8002);
    wr(12'h000, 32'h0000_0002);
    eng_u.pulse(7'h20);
    rdc(12'h000, 32'h0);
    eng_u.pulse(7'h60);
    rdc(12'h000, 32'h0001_0001);
    wr(12'h000, 32'h0000_0001);
    rdc(12'h000, 32'h0);
    $display("done test done");
  endtask
  // Suspend on a missing descriptor, then resume.
  task automatic t_suspend();
    eng_u.pulse(7'h08);
    #1;
    chk(tx_state, 32'h4);
    rdc(12'h000, 32'h0001_0004);
    eng_u.pulse(7'h10);
    #1;
    chk(tx_state, 32'h4);
    eng_u.resume();
    #1;
    chk(tx_state, 32'h2);
    wr(12'h000, 32'h0000_0004);
    $display("suspend test done");
  endtask
  // Jabber stops the engine and flags the descriptor once.
  task automatic t_jabber();
    eng_u.pulse(7'h04);
    #1;
    chk(desc_jabber_flag, 32'h1);
    chk(tx_state, 32'h1);
    @(posedge hclk);
    #1;
    chk(desc_jabber_flag, 32'h0);
    rdc(12'h000, 32'h0000_800a);
    eng_u.pulse(7'h04);
    #1;
    chk(desc_jabber_flag, 32'h0);
    wr(12'h000, 32'h0000_000a);
    rdc(12'h000, 32'h0000_8002);
    $display("jabber test done");
  endtask
  // Control fields, start levels and a refused write while running.
  task automatic t_access();
    wr(12'h004, 32'h0020_c000);
    rdc(12'h004, 32'h0020_c000);
    #1;
    chk(sqe_test_en, 32'h1);
    @(posedge hclk);
    fifo_bytes <= 11'h7ff;
    #1;
    chk(line_start_ok, 32'h0);
    @(posedge hclk);
    frame_whole <= 1'b1;
    #1;
    chk(line_start_ok, 32'h1);
    for (int i = 0; i < 8; i++)
    begin
      wr(12'h004, {16'h0, i[1:0], 14'h0});
      link_fast <= ~i[2];
      frame_whole <= 1'b0;
      fifo_bytes <= LVL[i] - 11'h001;
      #1;
      chk(line_start_ok, 32'h0);
      chk(sqe_test_en, {31'h0, i[2]});
      @(posedge hclk);
      fifo_bytes <= LVL[i];
      #1;
      chk(line_start_ok, 32'h1);
    end
    eng_u.pulse(7'h01);
    wr(12'h004, 32'h0020_0000);
    rdc(12'h004, 32'h0000_c000);
    eng_u.pulse(7'h04);
    wr(12'h000, 32'h0000_000f);
    $display("access test done");
  endtask
  // Masked interrupt from the completion flag.
  task automatic t_irq();
    wr(12'h008, 32'h0000_0001);
    #1;
    chk(irq, 32'h0);
    eng_u.pulse(7'h01);
    eng_u.pulse(7'h60);
    #1;
    chk(irq, 32'h1);
    wr(12'h008, 32'h0);
    #1;
    chk(irq, 32'h0);
    wr(12'h008, 32'h0000_0001);
    wr(12'h000, 32'h0000_0001);
    #1;
    chk(irq, 32'h0);
    $display("irq test done");
  endtask
  //////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    frame_whole = 1'b0;
    link_fast = 1'b0;
    haddr = 12'h000;
    htrans = 2'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
    fifo_bytes = 11'h000;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_done();
    t_suspend();
    t_jabber();
    t_access();
    t_irq();
    tally_and_finish();
  end
  // Cuts a hang short.
  initial
  begin
    #500000;
    error_cnt++;
    tally_and_finish();
  end
endmodule
